// File: hdl/bstp_top.sv
// bstp_top: boundary-scan test port with tap controller and pin cells
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - every input and i/o pin has a cell
// - no test reset pin; reset at power-up
// - five instructions: sample, extest, bypass, idcode, highz
// - port disabled frees its four pins
// - programming uses the standard four-wire protocol
// - chain covers 32 i/o and 4 inputs
// - i/o cell: three capture, two update stages
// - separate cell variants for pins and macrocells
// - cells chained from tdi to tdo
// - capture samples, shift passes, update transfers
// - cell controls come from the tap controller
// - test pins share macrocells 4, 9, 20, 25
// - fuse hides macrocell state, signature stays readable
// - interrupted programming locks pins high-impedance
module bstp_top #(
   parameter int          N_IO       = bstp_pkg::N_IO, // bidirectional pins
   parameter int          N_IN       = bstp_pkg::N_IN, // dedicated inputs
   parameter int          N_MC       = bstp_pkg::N_MC, // macrocells
   parameter logic [31:0] IDCODE_VAL = 32'h0A5A_5001   // arbitrary value
) (
   input  wire logic              clk_i,       // system clock
   input  wire logic              rst_i,       // synchronous reset
   input  wire logic              tck_i,       // test clock
   input  wire logic              tms_i,       // test mode select
   input  wire logic              tdi_i,       // test data in
   output logic                   tdo_o,       // test data out
   output logic                   tdo_oe_o,    // tdo driven
   input  wire logic              port_en_i,   // test port enabled
   input  wire logic              fuse_i,      // copy-protection fuse
   input  wire logic              isp_abort_i, // programming interrupted
   input  wire logic [N_IO-1:0]   io_pin_i,    // i/o pin levels
   input  wire logic [N_IN-1:0]   in_pin_i,    // input pin levels
   input  wire logic [N_MC-1:0]   mc_state_i,  // macrocell states
   input  wire logic [N_IO-1:0]   core_out_i,  // core output data
   input  wire logic [N_IO-1:0]   core_oe_i,   // core output enables
   output logic [N_IO-1:0]        pad_out_o,   // pad output data
   output logic [N_IO-1:0]        pad_oe_o,    // pad output enables
   output logic                   isp_lock_o,  // pins locked off
   output logic                   upd_valid_o, // update word ready
   output logic [2*N_IO+1:0]      upd_data_o,  // {hiz, ext, oe, out}
   input  wire logic              upd_ready_i  // update word taken
);
   localparam int NB  = bstp_pkg::CELL_W * N_IO + N_IN + N_MC; // chain length
   localparam int SW  = NB + 4;                                // synced width
   localparam int UW  = 2 * N_IO + bstp_pkg::MODE_W;           // update word

   // chain register chosen by an instruction
   function automatic bstp_pkg::bstp_sel_t dr_sel(input logic [3:0] ins);
      case (ins)
         bstp_pkg::INS_EXTEST, bstp_pkg::INS_SAMPLE: dr_sel = bstp_pkg::SEL_BR;
         bstp_pkg::INS_IDCODE:                       dr_sel = bstp_pkg::SEL_ID;
         default:                                    dr_sel = bstp_pkg::SEL_BYP;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // test-clock side: three-stage synchronisers for everything foreign
   logic [SW-1:0] s1_q, s2_q, s3_q;  // synchroniser stages
   logic [SW-1:0] f_q, f_d;          // agreed values
   logic [SW-1:0] raw;               // foreign levels
   logic          ack_q;             // clock-side acknowledge toggle, crosses back here
   assign raw = {rst_i, port_en_i, fuse_i, ack_q, mc_state_i, core_oe_i,
                 core_out_i, in_pin_i, io_pin_i};

   // a change counts once the second and third stage agree
   always_comb
   begin
      f_d = (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge tck_i)
   begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
   end

   logic            rst_f, en_f, fuse_f, ack_f;
   logic [N_IO-1:0] io_f, out_f, oe_f;
   logic [N_IN-1:0] in_f;
   logic [N_MC-1:0] mc_f;

   assign io_f   = f_q[N_IO-1:0];
   assign in_f   = f_q[N_IO+N_IN-1:N_IO];
   assign out_f  = f_q[2*N_IO+N_IN-1:N_IO+N_IN];
   assign oe_f   = f_q[3*N_IO+N_IN-1:2*N_IO+N_IN];
   assign mc_f   = f_q[NB-1:3*N_IO+N_IN];
   assign rst_f  = f_q[SW-1];
   assign en_f   = f_q[SW-2];
   assign fuse_f = f_q[SW-3];
   assign ack_f  = f_q[SW-4];

   // tap held in reset at power-up and while the port is off
   logic tap_rst;
   assign tap_rst = rst_f | ~en_f;

   ////////////////////////////////////////////////////////////////////////////
   // capture values, laid out in chain order
   logic [NB-1:0] cap;
   genvar gi;
   generate
      // pin variant: i/o cell with three capture stages
      for (gi = 0; gi < N_IO; gi++)
      begin : g_io
         assign cap[bstp_pkg::CELL_W*gi+bstp_pkg::IO_IN]  = io_f[gi];
         assign cap[bstp_pkg::CELL_W*gi+bstp_pkg::IO_OUT] = out_f[gi];
         assign cap[bstp_pkg::CELL_W*gi+bstp_pkg::IO_OE]  = oe_f[gi];
      end
      // pin variant: dedicated input, capture only
      for (gi = 0; gi < N_IN; gi++)
      begin : g_in
         assign cap[bstp_pkg::CELL_W*N_IO+gi] = in_f[gi];
      end
      // macrocell variant; fuse hides the pattern
      for (gi = 0; gi < N_MC; gi++)
      begin : g_mc
         assign cap[bstp_pkg::CELL_W*N_IO+N_IN+gi] = mc_f[gi] & ~fuse_f;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // tap controller, instruction and data registers
   bstp_pkg::bstp_tap_t st_q, st_d;     // tap state
   logic [3:0]          ir_sh_q, ir_sh_d; // instruction shift stage
   logic [3:0]          ir_q, ir_d;       // current instruction
   logic                byp_q, byp_d;     // bypass bit
   logic [31:0]         id_q, id_d;       // identification shift
   logic [NB-1:0]       br_q, br_d;       // capture/shift stages
   logic [N_IO-1:0]     uout_q, uout_d;   // update stage: data
   logic [N_IO-1:0]     uoe_q, uoe_d;     // update stage: enable
   bstp_pkg::bstp_sel_t sel;

   assign sel = dr_sel(ir_q);

   // next state follows tms; register actions by state
   always_comb
   begin
      st_d    = st_q;
      ir_sh_d = ir_sh_q;
      ir_d    = ir_q;
      byp_d   = byp_q;
      id_d    = id_q;
      br_d    = br_q;
      uout_d  = uout_q;
      uoe_d   = uoe_q;
      case (st_q)
         bstp_pkg::ST_RESET:  st_d = tms_i ? bstp_pkg::ST_RESET  : bstp_pkg::ST_IDLE;
         bstp_pkg::ST_IDLE:   st_d = tms_i ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
         bstp_pkg::ST_SEL_DR: st_d = tms_i ? bstp_pkg::ST_SEL_IR : bstp_pkg::ST_CAP_DR;
         bstp_pkg::ST_CAP_DR: st_d = tms_i ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
         bstp_pkg::ST_SH_DR:  st_d = tms_i ? bstp_pkg::ST_EX1_DR : bstp_pkg::ST_SH_DR;
         bstp_pkg::ST_EX1_DR: st_d = tms_i ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_PA_DR;
         bstp_pkg::ST_PA_DR:  st_d = tms_i ? bstp_pkg::ST_EX2_DR : bstp_pkg::ST_PA_DR;
         bstp_pkg::ST_EX2_DR: st_d = tms_i ? bstp_pkg::ST_UPD_DR : bstp_pkg::ST_SH_DR;
         bstp_pkg::ST_UPD_DR: st_d = tms_i ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
         bstp_pkg::ST_SEL_IR: st_d = tms_i ? bstp_pkg::ST_RESET  : bstp_pkg::ST_CAP_IR;
         bstp_pkg::ST_CAP_IR: st_d = tms_i ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
         bstp_pkg::ST_SH_IR:  st_d = tms_i ? bstp_pkg::ST_EX1_IR : bstp_pkg::ST_SH_IR;
         bstp_pkg::ST_EX1_IR: st_d = tms_i ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_PA_IR;
         bstp_pkg::ST_PA_IR:  st_d = tms_i ? bstp_pkg::ST_EX2_IR : bstp_pkg::ST_PA_IR;
         bstp_pkg::ST_EX2_IR: st_d = tms_i ? bstp_pkg::ST_UPD_IR : bstp_pkg::ST_SH_IR;
         bstp_pkg::ST_UPD_IR: st_d = tms_i ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
         default:             st_d = bstp_pkg::ST_RESET;
      endcase
      // cell controls are decoded here, never taken from pins
      case (st_q)
         bstp_pkg::ST_RESET:  ir_d = bstp_pkg::IR_RST;
         bstp_pkg::ST_CAP_IR: ir_sh_d = bstp_pkg::IR_CAPT;
         bstp_pkg::ST_SH_IR:  ir_sh_d = {tdi_i, ir_sh_q[3:1]};
         bstp_pkg::ST_UPD_IR: ir_d = ir_sh_q;
         bstp_pkg::ST_CAP_DR:
         begin
            byp_d = 1'b0;
            id_d  = IDCODE_VAL;
            if (sel == bstp_pkg::SEL_BR)
               br_d = cap;
         end
         bstp_pkg::ST_SH_DR:
         begin
            if (sel == bstp_pkg::SEL_BYP)
               byp_d = tdi_i;
            if (sel == bstp_pkg::SEL_ID)
               id_d = {tdi_i, id_q[31:1]};
            if (sel == bstp_pkg::SEL_BR)
               br_d = {tdi_i, br_q[NB-1:1]};
         end
         bstp_pkg::ST_UPD_DR:
         begin
            // sample/preload and extest both load the update stages
            if (sel == bstp_pkg::SEL_BR)
            begin
               for (int i = 0; i < N_IO; i++)
               begin
                  uout_d[i] = br_q[bstp_pkg::CELL_W*i+bstp_pkg::IO_OUT];
                  uoe_d[i]  = br_q[bstp_pkg::CELL_W*i+bstp_pkg::IO_OE];
               end
            end
         end
         default:
         begin
         end
      endcase
   end

   always_ff @(posedge tck_i)
   begin
      if (tap_rst)
      begin
         st_q    <= bstp_pkg::ST_RESET;
         ir_sh_q <= '0;
         ir_q    <= bstp_pkg::IR_RST;
         byp_q   <= 1'b0;
         id_q    <= '0;
         br_q    <= '0;
         uout_q  <= '0;
         uoe_q   <= '0;
      end
      else
      begin
         st_q    <= st_d;
         ir_sh_q <= ir_sh_d;
         ir_q    <= ir_d;
         byp_q   <= byp_d;
         id_q    <= id_d;
         br_q    <= br_d;
         uout_q  <= uout_d;
         uoe_q   <= uoe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tdo changes on the falling test clock, as the far end expects
   logic tdo_d, tdo_oe_d;
   always_comb
   begin
      tdo_oe_d = (st_q == bstp_pkg::ST_SH_DR) | (st_q == bstp_pkg::ST_SH_IR);
      if (st_q == bstp_pkg::ST_SH_IR)
         tdo_d = ir_sh_q[0];
      else if (sel == bstp_pkg::SEL_ID)
         tdo_d = id_q[0];
      else if (sel == bstp_pkg::SEL_BR)
         tdo_d = br_q[0];
      else
         tdo_d = byp_q;
   end

   always_ff @(negedge tck_i)
   begin
      if (tap_rst)
      begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end
      else
      begin
         tdo_o    <= tdo_d;
         tdo_oe_o <= tdo_oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // toggle handshake carrying the update word to the system clock;
   // the latest word always gets through, earlier ones may be merged
   logic          req_q, req_d;     // request toggle
   logic [UW-1:0] hold_q, hold_d;   // word held stable while in flight
   logic          dirty_q, dirty_d; // word changed since last send
   logic          upd_ev, busy;
   logic [UW-1:0] word;

   assign word   = {ir_d == bstp_pkg::INS_HIGHZ, ir_d == bstp_pkg::INS_EXTEST, uoe_d, uout_d};
   assign upd_ev = (st_q == bstp_pkg::ST_UPD_DR) | (st_q == bstp_pkg::ST_UPD_IR)
                 | (st_q == bstp_pkg::ST_RESET);
   assign busy   = req_q ^ ack_f;

   // next values are sent, so an update leaves on its own edge even if tck stops
   always_comb
   begin
      req_d   = req_q;
      hold_d  = hold_q;
      dirty_d = dirty_q | upd_ev;
      if (!busy && dirty_d)
      begin
         hold_d  = word;
         req_d   = ~req_q;
         dirty_d = 1'b0;
      end
   end

   always_ff @(posedge tck_i)
   begin
      if (rst_f)
      begin
         req_q   <= 1'b0;
         hold_q  <= '0;
         dirty_q <= 1'b1;
      end
      else
      begin
         req_q   <= req_d;
         hold_q  <= hold_d;
         dirty_q <= dirty_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // system-clock side: request synchroniser and pad drivers
   logic            rq1_q, rq2_q, rq3_q, rqf_q, rqf_d; // request stages
   logic            ack_d, pend, push, buf_rdy;
   logic [N_IO-1:0] drv_out_q, drv_out_d, drv_oe_q, drv_oe_d;
   logic            ext_q, ext_d, hiz_q, hiz_d, lock_q, lock_d;
   logic [N_IO-1:0] pad_out_d, pad_oe_d;

   assign pend = rqf_q ^ ack_q;
   assign push = pend & buf_rdy;   // a stalled buffer holds off the ack

   always_comb
   begin
      rqf_d     = (rq2_q & rq3_q) | (rqf_q & (rq2_q ^ rq3_q));
      ack_d     = push ? ~ack_q : ack_q;
      drv_out_d = push ? hold_q[N_IO-1:0] : drv_out_q;
      drv_oe_d  = push ? hold_q[2*N_IO-1:N_IO] : drv_oe_q;
      ext_d     = push ? hold_q[2*N_IO+bstp_pkg::MODE_EXT] : ext_q;
      hiz_d     = push ? hold_q[2*N_IO+bstp_pkg::MODE_HIZ] : hiz_q;
      lock_d    = lock_q | isp_abort_i;
      for (int i = 0; i < N_IO; i++)
      begin
         pad_out_d[i] = ext_q ? drv_out_q[i] : core_out_i[i];
         pad_oe_d[i]  = ~lock_q & ~hiz_q
                      & (ext_q ? drv_oe_q[i] : core_oe_i[i]);
         // shared test pins are not user outputs while the port is on
         if (port_en_i && (i == bstp_pkg::PIN_TDI || i == bstp_pkg::PIN_TMS
             || i == bstp_pkg::PIN_TDO || i == bstp_pkg::PIN_TCK))
            pad_oe_d[i] = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      rq1_q <= req_q;
      rq2_q <= rq1_q;
      rq3_q <= rq2_q;
      if (rst_i)
      begin
         rqf_q     <= 1'b0;
         ack_q     <= 1'b0;
         drv_out_q <= '0;
         drv_oe_q  <= '0;
         ext_q     <= 1'b0;
         hiz_q     <= 1'b0;
         lock_q    <= 1'b0;
         pad_out_o <= '0;
         pad_oe_o  <= '0;
         isp_lock_o <= 1'b0;
      end
      else
      begin
         rqf_q     <= rqf_d;
         ack_q     <= ack_d;
         drv_out_q <= drv_out_d;
         drv_oe_q  <= drv_oe_d;
         ext_q     <= ext_d;
         hiz_q     <= hiz_d;
         lock_q    <= lock_d;
         pad_out_o <= pad_out_d;
         pad_oe_o  <= pad_oe_d;
         isp_lock_o <= lock_d;
      end
   end

   // every accepted word is also streamed out for observation
   bstp_buf2 #(
      .WIDTH (UW)
   ) u_buf (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (pend),
      .in_ready_o  (buf_rdy),
      .in_data_i   (hold_q),
      .out_valid_o (upd_valid_o),
      .out_ready_i (upd_ready_i),
      .out_data_o  (upd_data_o)
   );
endmodule
`default_nettype wire

// File: hdl/bstp_pkg.sv
// bstp_pkg: constants and types shared by the boundary-scan test port
`default_nettype none
package bstp_pkg;
   // instruction register
   localparam int         IR_W        = 4;     // instruction register width
   localparam logic [3:0] INS_EXTEST  = 4'h0;  // drive pins from update stages
   localparam logic [3:0] INS_SAMPLE  = 4'h1;  // sample / preload
   localparam logic [3:0] INS_IDCODE  = 4'h2;  // identification register
   localparam logic [3:0] INS_HIGHZ   = 4'h3;  // all outputs off, bypass
   localparam logic [3:0] INS_BYPASS  = 4'hF;  // one-bit bypass
   localparam logic [3:0] IR_CAPT     = 4'h1;  // value caught in capture-ir
   localparam logic [3:0] IR_RST      = INS_IDCODE; // instruction after reset

   // register widths and pin counts
   localparam int ID_W = 32;  // identification register width
   localparam int N_IO = 32;  // bidirectional pins
   localparam int N_IN = 4;   // dedicated input pins
   localparam int N_MC = 32;  // macrocells

   // layout of one pin cell in the chain
   localparam int CELL_W = 3; // capture stages per i/o cell
   localparam int IO_IN  = 0; // pin level
   localparam int IO_OUT = 1; // output data
   localparam int IO_OE  = 2; // output enable

   // i/o positions (zero based) shared with the test port
   localparam int PIN_TDI = 3;
   localparam int PIN_TMS = 8;
   localparam int PIN_TDO = 19;
   localparam int PIN_TCK = 24;

   // mode bits at the top of the update word
   localparam int MODE_EXT = 0; // extest active
   localparam int MODE_HIZ = 1; // highz active
   localparam int MODE_W   = 2;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } bstp_tap_t;

   typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_BR} bstp_sel_t;
endpackage
`default_nettype wire

// File: hdl/bstp_buf2.sv
// bstp_buf2: two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ns
`default_nettype none
module bstp_buf2 #(
   parameter int WIDTH = 8              // word width
) (
   input  wire logic             clk_i,  // clock
   input  wire logic             rst_i,  // synchronous reset
   input  wire logic             in_valid_i, // word offered
   output logic                  in_ready_o, // room for a word
   input  wire logic [WIDTH-1:0] in_data_i,  // offered word
   output logic                  out_valid_o, // head holds a word
   input  wire logic             out_ready_i, // drain accepts head
   output logic [WIDTH-1:0]      out_data_o   // head word
);
   logic [WIDTH-1:0] head_q, head_d; // entry seen at the output
   logic [WIDTH-1:0] tail_q, tail_d; // second entry
   logic             hv_q, hv_d;     // head valid
   logic             tv_q, tv_d;     // tail valid
   logic             push, pop;

   ////////////////////////////////////////////////////////////////////////////
   // next values; ready is a register so full is honest a cycle ahead
   always_comb
   begin
      head_d = head_q;
      tail_d = tail_q;
      hv_d   = hv_q;
      tv_d   = tv_q;
      push   = in_valid_i & ~tv_q;
      pop    = hv_q & out_ready_i;
      if (pop)
      begin
         if (tv_q)
         begin
            // tail moves up, no push possible while tail is full
            head_d = tail_q;
            tv_d   = 1'b0;
         end
         else if (push)
            head_d = in_data_i;
         else
            hv_d = 1'b0;
      end
      else if (push)
      begin
         if (!hv_q)
         begin
            head_d = in_data_i;
            hv_d   = 1'b1;
         end
         else
         begin
            tail_d = in_data_i;
            tv_d   = 1'b1;
         end
      end
   end

   // registers only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         head_q <= '0;
         tail_q <= '0;
         hv_q   <= 1'b0;
         tv_q   <= 1'b0;
      end
      else
      begin
         head_q <= head_d;
         tail_q <= tail_d;
         hv_q   <= hv_d;
         tv_q   <= tv_d;
      end
   end

   assign in_ready_o  = ~tv_q;
   assign out_valid_o = hv_q;
   assign out_data_o  = head_q;
endmodule
`default_nettype wire

// File: tb/bstp_asserts.sv
// bstp_asserts: port checks of the scan port
`timescale 1ns/1ns
`default_nettype none
module bstp_asserts #(
   parameter int N_IO = 32 // i/o pins
) (
   input wire logic              clk_i,       // clock
   input wire logic              rst_i,       // reset
   input wire logic              tck_i,       // test clock
   input wire logic              tms_i,       // mode select
   input wire logic              port_en_i,   // port on
   input wire logic              isp_abort_i, // abort
   input wire logic              tdo_oe_o,    // tdo driven
   input wire logic              isp_lock_o,  // lock
   input wire logic [N_IO-1:0]   pad_oe_o,    // pad enables
   input wire logic              upd_valid_o, // head valid
   input wire logic              upd_ready_i, // head taken
   input wire logic [2*N_IO+1:0] upd_data_o   // head word
);
   ////////////////////////////////////////////////////////////
   // pad side: a lock beats every other drive source
   property p_lock_oe; @(posedge clk_i) disable iff (rst_i)
      isp_lock_o && $past(isp_lock_o) |-> pad_oe_o == '0; endproperty
   a_lock_oe: assert property (p_lock_oe) else $error("pad on while locked");
   property p_abort; @(posedge clk_i) disable iff (rst_i)
      isp_abort_i |-> ##[1:2] isp_lock_o; endproperty
   a_abort: assert property (p_abort) else $error("abort did not lock");
   property p_sticky; @(posedge clk_i) disable iff (rst_i)
      isp_lock_o |=> isp_lock_o; endproperty
   a_sticky: assert property (p_sticky) else $error("lock dropped");
   // shared pins stay released while the port owns them
   property p_tap_pins; @(posedge clk_i) disable iff (rst_i) port_en_i && $past(port_en_i)
      |-> !(pad_oe_o[3] | pad_oe_o[8] | pad_oe_o[19] | pad_oe_o[24]); endproperty
   a_tap_pins: assert property (p_tap_pins) else $error("test pin driven");
   ////////////////////////////////////////////////////////////
   // buffer: a stalled head must not change or vanish
   property p_hold; @(posedge clk_i) disable iff (rst_i)
      upd_valid_o && !upd_ready_i |=> upd_valid_o && $stable(upd_data_o); endproperty
   a_hold: assert property (p_hold) else $error("stalled word lost");
   property p_drop; @(posedge clk_i) disable iff (rst_i)
      $fell(upd_valid_o) |-> $past(upd_ready_i); endproperty
   a_drop: assert property (p_drop) else $error("word dropped unasked");
   ////////////////////////////////////////////////////////////
   // tap side: disabled port and five ones both park the tap
   property p_off; @(posedge tck_i) disable iff (rst_i)
      !port_en_i && !$past(port_en_i) |-> !tdo_oe_o; endproperty
   a_off: assert property (p_off) else $error("tdo on while disabled");
   property p_tms5; @(posedge tck_i) disable iff (rst_i)
      tms_i [*5] |=> !tdo_oe_o; endproperty
   a_tms5: assert property (p_tms5) else $error("tap not reset");
endmodule
bind bstp_top bstp_asserts #(.N_IO(N_IO)) bstp_asserts_i (.*);
`default_nettype wire

// File: tb/bstp_jtag.sv
// bstp_jtag: external controller driving the four-wire port
`timescale 1ns/1ns
`default_nettype none
module bstp_jtag (
   output logic     tck_o, // test clock, still between frames
   output logic     tms_o, // mode select
   output logic     tdi_o, // data in, pulled up when idle
   input wire logic tdo_i  // data out of the device
);
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   // one 125 ns cycle; tdo taken just before the rising edge
   task automatic step(input logic m, input logic d, output logic o);
      tms_o = m;
      tdi_o = d;
      #62 o = tdo_i;
      tck_o = 1'b1;
      #63 tck_o = 1'b0;
   endtask
   // five or more ones reach reset, a zero parks in idle
   task automatic rst_frame(input int n);
      logic o;
      repeat (n) step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask
   // whole-chain shift lsb first, then update and idle
   task automatic shift(input logic [131:0] d, input int n, output logic [131:0] q);
      logic o;
      q = '0;
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, d[i], o);
         q[i] = o;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
   endtask
   // only the five documented codes are ever sent
   task automatic scan_ir(input logic [3:0] c, output logic [3:0] q);
      logic o;
      logic [131:0] r;
      for (int i = 0; i < 4; i++) step(i < 2, 1'b1, o);
      shift({128'h0, c}, 4, r);
      q = r[3:0];
   endtask
   task automatic scan_dr(input logic [131:0] d, input int n, output logic [131:0] q);
      logic o;
      for (int i = 0; i < 3; i++) step(i == 0, 1'b1, o);
      shift(d, n, q);
   endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking bench of the boundary-scan test port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [31:0] ID   = 32'h1234_5678; // arbitrary identity value
   localparam logic [31:0] TAPM = 32'h0108_0108; // pins shared with the port
   localparam logic [31:0] PO   = 32'h3C96_0FA5; // preloaded pad data
   localparam logic [31:0] PE   = 32'hF0F0_5A5A; // preloaded pad enables
   logic         clk_i = 1'b0, rst_i = 1'b1, port_en_i = 1'b1, fuse_i = 1'b0;
   logic         isp_abort_i = 1'b0, upd_ready_i = 1'b1;
   logic         tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, isp_lock_o, upd_valid_o;
   logic [31:0]  io_pin_i = 32'h9A3C_5E71, mc_state_i = 32'hC35A_0FF1;
   logic [31:0]  core_out_i = 32'h5A5A_A5A5, core_oe_i = 32'hFFFF_FFFF;
   logic [31:0]  pad_out_o, pad_oe_o;
   logic [3:0]   in_pin_i = 4'h9, cap;
   logic [65:0]  upd_data_o;
   logic [131:0] dout, exp_v, msk, din;
   logic [1:0]   last;
   int           fail_count = 0, comparisons = 0;

   bstp_top #(.IDCODE_VAL(ID)) bstp_top_i (.*);
   bstp_jtag bstp_jtag_i (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));

   always #5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [131:0] got, input logic [131:0] want);
      comparisons++;
      if (got !== want)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, want);
      end
   endtask
   task automatic finish_test();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic clks(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic ir(input logic [3:0] c);
      bstp_jtag_i.scan_ir(c, cap);
      check(cap, bstp_pkg::IR_CAPT);
   endtask
   ////////////////////////////////////////////////////////////
   // identity: 32 bits exactly, readable under the fuse too
   task automatic t_ident();
      bstp_jtag_i.scan_dr(132'h1, 33, dout);
      check(dout[32:0], {1'b1, ID});
      @(posedge clk_i) fuse_i <= 1'b1;
      ir(bstp_pkg::INS_IDCODE);
      bstp_jtag_i.scan_dr(132'h1, 33, dout);
      check(dout[32:0], {1'b1, ID});
   endtask
   // bypass and highz: one-bit delay, highz kills all drive
   task automatic t_byp();
      for (int k = 0; k < 2; k++)
      begin
         ir(k ? bstp_pkg::INS_HIGHZ : bstp_pkg::INS_BYPASS);
         bstp_jtag_i.scan_dr(132'hB7, 8, dout);
         check(dout[7:0], 8'h6E);
         clks(10);
         check(pad_oe_o, k ? 32'h0 : core_oe_i & ~TAPM);
      end
   endtask
   // sample: pin, input and macrocell captures, fuse masks cells
   task automatic t_samp();
      for (int f = 0; f < 2; f++)
      begin
         @(posedge clk_i) fuse_i <= f[0];
         ir(bstp_pkg::INS_SAMPLE);
         bstp_jtag_i.scan_dr('0, 132, dout);
         msk = {36'hF_FFFF_FFFF, {32{3'b001}}};
         exp_v = '0;
         for (int i = 0; i < 32; i++) exp_v[3*i] = io_pin_i[i];
         exp_v[131:96] = {f ? 32'h0 : mc_state_i, in_pin_i};
         check(dout & msk, exp_v);
      end
   endtask
   // preload then extest drives pads from the update stages
   task automatic t_ext();
      din = '0;
      for (int i = 0; i < 32; i++) din[3*i+1] = PO[i];
      for (int i = 0; i < 32; i++) din[3*i+2] = PE[i];
      bstp_jtag_i.scan_dr(din, 132, dout);
      ir(bstp_pkg::INS_EXTEST);
      clks(10);
      check(pad_out_o, PO);
      check(pad_oe_o, PE & ~TAPM);
      ir(bstp_pkg::INS_SAMPLE);
      clks(10);
      check(pad_out_o, core_out_i);
   endtask
   // stalled consumer: first word held, latest word arrives last
   task automatic t_buf();
      @(posedge clk_i) upd_ready_i <= 1'b0;
      ir(bstp_pkg::INS_HIGHZ);
      ir(bstp_pkg::INS_BYPASS);
      ir(bstp_pkg::INS_SAMPLE);
      check(upd_valid_o, 1'b1);
      check(upd_data_o[65:64], 2'b10);
      @(posedge clk_i) upd_ready_i <= 1'b1;
      repeat (20) @(posedge clk_i) if (upd_valid_o) last = upd_data_o[65:64];
      check(last, 2'b00);
      check(upd_valid_o, 1'b0);
   endtask
   // disabled port frees its pins and keeps tdo off
   task automatic t_port();
      @(posedge clk_i) port_en_i <= 1'b0;
      bstp_jtag_i.rst_frame(5);
      check(tdo_oe_o, 1'b0);
      check(pad_oe_o, core_oe_i);
      @(posedge clk_i) port_en_i <= 1'b1;
      bstp_jtag_i.rst_frame(5);
   endtask
   // interrupted programming locks pads until a reset
   task automatic t_lock();
      @(posedge clk_i) isp_abort_i <= 1'b1;
      @(posedge clk_i) isp_abort_i <= 1'b0;
      clks(3);
      check(isp_lock_o, 1'b1);
      check(pad_oe_o, 32'h0);
      @(posedge clk_i) rst_i <= 1'b1;
      bstp_jtag_i.rst_frame(8);
      @(posedge clk_i) rst_i <= 1'b0;
      clks(2);
      check(isp_lock_o, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////
   // reset spans test clocks so the tap side sees it too
   initial
   begin
      bstp_jtag_i.rst_frame(8);
      @(posedge clk_i) rst_i <= 1'b0;
      bstp_jtag_i.rst_frame(5);
      t_ident();
      t_byp();
      t_samp();
      t_ext();
      t_buf();
      t_port();
      t_lock();
      finish_test();
   end
   // watchdog: about five times the expected run
   initial
   begin
      #400000;
      fail_count++;
      finish_test();
   end
endmodule
`default_nettype wire
